// *** quad_lane_byte_symbol_mapper.sv ***
// Purpose: XGMII word to byte symbol stream and back, with alignment
// Assumes: One symbol per clock each way; tx_even toggles every clock
// Notes:   Encoded words wait in a small FIFO ahead of the serializer
`timescale 1ns/1ps
module sym_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Behaviour
// RQ1 - Map data, idle, LPI and start words
// RQ2 - Terminate and later lanes become idle
// RQ3 - Sequence word output depends on encoder state
// RQ4 - Repeated sequence words form one set
// RQ5 - Pack 24 payload bits into four bytes
// RQ6 - Bit 6 follows bit 7 or 5
// RQ7 - Signal set clears bit 7 of byte 2
// RQ8 - Bit-7 pattern 01 marks set start
// RQ9 - Serialize index 0 first, 3 last
// RQ10 - Even indices presented while tx_even true
// RQ11 - Gather received symbols earliest at index 0
// RQ12 - Data after idle lands on index 0
// RQ13 - LPI/idle transitions land on 0 or 2
// RQ14 - Ordered set start lands on index 0
// RQ15 - Deficit counts deletes up, inserts down
// RQ16 - Deficit stays within zero to three
// RQ17 - Insert only idles, delete any symbol
// RQ18 - Decode data words and start character
// RQ19 - Decode idles and place terminate
// RQ20 - Decode LPI groups and LPI exits
// RQ21 - Decode sequence halves by state and flag
// RQ22 - Rebuild payload only on pattern 0110
// RQ23 - Symbol encodings for idle, LPI, Seq, CE
// RQ24 - Keep bytes 2 and 3 for next cycle
// RQ25 - Next-half flag uses one group lookahead
module quad_lane_byte_symbol_mapper
  import symbol_map_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] txd,
  input  wire logic [3:0]  txc,
  input  wire logic        tx_word_valid,
  output logic             tx_word_ready,
  input  wire logic        tx_even,
  output logic             tx_symbol_valid,
  output logic             tx_symbol_error,
  output logic [7:0]       tx_symbol_data,
  input  wire logic        rx_symbol_valid,
  input  wire logic        rx_symbol_error,
  input  wire logic [7:0]  rx_symbol_data,
  output logic [31:0]      rxd,
  output logic [3:0]       rxc,
  output logic             rx_word_strobe
);
  function automatic logic [7:0] fix6(logic [7:0] b);
    fix6    = b;
    fix6[6] = b[2] ? b[5] : b[7]; // RQ6
  endfunction

  function automatic logic [31:0] pack(logic [23:0] p, logic sig);
    pack[7:0]   = fix6({2'b00, p[5:0]}); // RQ5
    pack[15:8]  = fix6({2'b10, p[11:8], p[7:6]});
    pack[23:16] = fix6({~sig, 1'b0, p[17:16], p[15:12]}); // RQ7
    pack[31:24] = fix6({2'b00, p[23:18]});
  endfunction

  function automatic logic [8:0] to_xg(sym_t s);
    to_xg = s[8] ? {1'b1, XG_ERR} : {1'b0, s[7:0]};
  endfunction

  // Transmit side
  enc_state_t  enc_q;
  enc_state_t  enc_d;
  logic [15:0] s23_q;
  logic [15:0] s23_d;
  logic [31:0] seq_w;
  sym_t        enc_w [4];
  sym_t        ln_sym [4];
  logic [3:0]  ln_de;
  logic [3:0]  ln_idle;
  logic [3:0]  ln_lpi;
  logic [3:0]  ln_term;
  logic [3:0]  mlo;
  logic [3:0]  mhi;
  logic        t_hit;
  logic [1:0]  t_k;
  logic        is_seqw;
  logic        enc_push;
  logic [39:0] fifo_out;
  logic        fifo_ov;
  logic        ser_end;
  logic        pair_q;
  logic [39:0] word_q;
  sym_t        tx_sym_q;
  // Receive side
  sym_t        la_q [4];
  sym_t        prev_q;
  sym_t        cur;
  sym_t        grp_q [4];
  sym_t        g [4];
  sym_t        grp_new [4];
  sym_t        grp_out [4];
  logic [1:0]  slot_q;
  logic [1:0]  pos;
  logic [1:0]  dic_q;
  logic [1:0]  dic_d;
  logic [2:0]  ins_n;
  logic        fill_emit;
  logic        grp_emit;
  logic        set_start;
  logic        need0;
  logic        need02;
  logic        mis0;
  logic        mis02;
  sym_t        hold_q [4];
  logic        hold_v_q;
  logic [3:0]  h_de;
  logic [3:0]  h_idle;
  logic [3:0]  h_lpi;
  logic [3:0]  h_ce;
  logic        h_shape;
  logic        n_shape;
  logic        first_half;
  logic        next_half_present;
  logic        pat_ok;
  logic [23:0] xyz;
  logic [23:0] xyz_q;
  logic [23:0] xyz_d;
  logic        seqok_q;
  logic        seqok_d;
  logic [8:0]  d_w [4];
  dec_state_t  dec_q;
  dec_state_t  dec_d;
  logic        dec_go;
  logic        dt_hit;
  logic [1:0]  dt_k;

  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign ln_de[i]   = !txc[i] || txd[8*i+7 -: 8] == XG_ERR;
    assign ln_idle[i] = txc[i] && txd[8*i+7 -: 8] == XG_IDLE;
    assign ln_lpi[i]  = txc[i] && txd[8*i+7 -: 8] == XG_LPI;
    assign ln_term[i] = txc[i] && txd[8*i+7 -: 8] == XG_TERM;
    assign ln_sym[i]  = {1'b1, txc[i], txd[8*i+7 -: 8]};
    assign h_de[i]    = hold_q[i][9];
    assign h_idle[i]  = hold_q[i][9:8] == 2'b00; // RQ23
    assign h_lpi[i]   = hold_q[i] == SYM_LPI;
    assign h_ce[i]    = hold_q[i] == SYM_CE;
  end

  // Word encode
  assign is_seqw  = txc == 4'h1 && (txd[7:0] == XG_SEQ || txd[7:0] == XG_SIG);
  assign seq_w    = pack(txd[31:8], txd[7:0] == XG_SIG);
  assign enc_push = tx_word_valid && tx_word_ready;

  always_comb begin
    mlo   = '0;
    mhi   = '0;
    t_hit = 1'b0;
    t_k   = '0;
    for (int k = 0; k < 4; k++) begin
      mlo = 4'((5'h01 << k) - 5'h01);
      mhi = 4'(5'h1E << k);
      if (ln_term[k] && (ln_de | ~mlo) == XGC_ALL && (ln_idle | ~mhi) == XGC_ALL) begin
        t_hit = 1'b1;
        t_k   = 2'(k);
      end
    end
  end

  always_comb begin
    enc_w = '{SYM_ERR, SYM_ERR, SYM_ERR, SYM_ERR}; // RQ2
    enc_d = ENC_DATA;
    s23_d = s23_q;
    if (&ln_de) begin
      enc_w = ln_sym; // RQ1
    end else if (&ln_idle) begin
      enc_w = '{SYM_IDLE, SYM_IDLE, SYM_IDLE, SYM_IDLE}; // RQ1
      enc_d = ENC_IDLE;
    end else if (&ln_lpi) begin
      enc_w = '{SYM_LPI, SYM_LPI, SYM_LPI, SYM_LPI}; // RQ1
    end else if (txc[0] && txd[7:0] == XG_SOP && &ln_de[3:1]) begin
      enc_w    = ln_sym;
      enc_w[0] = {2'b10, PREAMBLE}; // RQ1
    end else if (t_hit) begin
      for (int i = 0; i < 4; i++) begin
        enc_w[i] = (2'(i) < t_k) ? ln_sym[i] : SYM_IDLE; // RQ2
      end
      enc_d = (t_k == 2'h0) ? ENC_IDLE : ENC_DATA;
    end else if (is_seqw) begin
      enc_d = ENC_IDLE;
      case (enc_q)
        ENC_IDLE: begin
          enc_w = '{SYM_SEQ, {2'b10, seq_w[7:0]}, SYM_SEQ, {2'b10, seq_w[15:8]}}; // RQ3
          s23_d = seq_w[31:16]; // RQ24
          enc_d = ENC_SEQ;
        end
        ENC_SEQ: begin
          // Second word of a run is ignored; bytes come from the first
          enc_w = '{SYM_SEQ, {2'b10, s23_q[7:0]}, SYM_SEQ, {2'b10, s23_q[15:8]}}; // RQ4
        end
        default: begin
          enc_w = '{SYM_IDLE, SYM_IDLE, SYM_IDLE, SYM_IDLE}; // RQ3
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enc_q <= ENC_IDLE;
      s23_q <= '0;
    end else if (enc_push) begin
      enc_q <= enc_d;
      s23_q <= s23_d;
    end
  end

  sym_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   ({enc_w[3], enc_w[2], enc_w[1], enc_w[0]}),
    .in_valid  (tx_word_valid),
    .in_ready  (tx_word_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_ov),
    .out_ready (ser_end)
  );

  // Serializer: the flop output shows next cycle, when tx_even has flipped
  assign ser_end = pair_q && tx_even;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pair_q   <= 1'b0;
      word_q   <= {4{SYM_IDLE}};
      tx_sym_q <= SYM_IDLE;
    end else begin
      pair_q   <= pair_q ^ tx_even;
      tx_sym_q <= word_q[SYM_W*{pair_q, tx_even} +: SYM_W]; // RQ9 RQ10
      if (ser_end) begin
        word_q <= fifo_ov ? fifo_out : {4{SYM_IDLE}};
      end
    end
  end

  assign tx_symbol_valid = tx_sym_q[9];
  assign tx_symbol_error = tx_sym_q[8];
  assign tx_symbol_data  = tx_sym_q[7:0];

  // Aligner, looking three symbols ahead for set boundaries
  assign cur       = la_q[0];
  assign set_start = cur == SYM_SEQ && la_q[1][9:8] == 2'b10 && !la_q[1][7]
                   && la_q[2] == SYM_SEQ && la_q[3][9:8] == 2'b10 && la_q[3][7]; // RQ8
  assign need0     = (prev_q[9:8] == 2'b00 && cur[9]) || set_start;
  assign need02    = (prev_q[9:8] == 2'b00 && cur == SYM_LPI)
                   || (prev_q == SYM_LPI && cur[9:8] == 2'b00);
  assign mis0      = need0 && slot_q != 2'h0;
  assign mis02     = !need0 && need02 && slot_q[0];

  always_comb begin
    g         = grp_q;
    fill_emit = 1'b0;
    pos       = slot_q;
    dic_d     = dic_q;
    ins_n     = 3'h4 - {1'b0, slot_q};
    if (mis0) begin
      pos = 2'h0; // RQ12 RQ14
      if ({1'b0, dic_q} + {1'b0, slot_q} <= {1'b0, DIC_MAX}) begin
        dic_d = dic_q + slot_q; // RQ15 RQ17
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (2'(i) >= slot_q) begin
            g[i] = SYM_IDLE; // RQ17
          end
        end
        fill_emit = 1'b1;
        dic_d = ({1'b0, dic_q} > ins_n) ? 2'({1'b0, dic_q} - ins_n) : 2'h0; // RQ16
      end
    end else if (mis02) begin
      if (dic_q != DIC_MAX) begin
        dic_d = dic_q + 2'h1; // RQ15 RQ16
        pos   = slot_q - 2'h1; // RQ13
      end else begin
        g[slot_q] = SYM_IDLE;
        dic_d     = dic_q - 2'h1; // RQ15
        fill_emit = slot_q == 2'h3;
        pos       = slot_q + 2'h1; // RQ13
      end
    end
    grp_new      = g;
    grp_new[pos] = cur; // RQ11
    grp_emit     = fill_emit || pos == 2'h3;
    grp_out      = fill_emit ? g : grp_new;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      la_q   <= '{SYM_IDLE, SYM_IDLE, SYM_IDLE, SYM_IDLE};
      grp_q  <= '{SYM_IDLE, SYM_IDLE, SYM_IDLE, SYM_IDLE};
      prev_q <= SYM_IDLE;
      slot_q <= SLOT_RST;
      dic_q  <= DIC_RESET;
    end else begin
      la_q   <= '{la_q[1], la_q[2], la_q[3], {rx_symbol_valid, rx_symbol_error, rx_symbol_data}};
      grp_q  <= grp_new;
      prev_q <= cur;
      slot_q <= pos + 2'h1;
      dic_q  <= dic_d;
    end
  end

  // Decoder, one group behind so the next group can be inspected
  assign dec_go  = grp_emit && hold_v_q;
  assign h_shape = hold_q[0] == SYM_SEQ && hold_q[1][9:8] == 2'b10
                 && hold_q[2] == SYM_SEQ && hold_q[3][9:8] == 2'b10;
  assign n_shape = grp_out[0] == SYM_SEQ && grp_out[1][9:8] == 2'b10
                 && grp_out[2] == SYM_SEQ && grp_out[3][9:8] == 2'b10;
  assign first_half        = h_shape && !hold_q[1][7] && hold_q[3][7];
  assign next_half_present = n_shape && !grp_out[3][7]; // RQ25
  assign pat_ok = {hold_q[1][7], hold_q[3][7], grp_out[1][7], grp_out[3][7]} == SEQ_PAT;
  assign xyz    = {grp_out[3][5:0], grp_out[1][5:4], grp_out[1][3:0], hold_q[3][5:2],
                   hold_q[3][1:0], hold_q[1][5:0]}; // RQ22

  always_comb begin
    dt_hit = 1'b0;
    dt_k   = '0;
    for (int k = 3; k >= 0; k--) begin
      if ((h_de | ~4'((5'h01 << k) - 5'h01)) == XGC_ALL && (h_idle[k] || (k > 0 && h_ce[k]))
          && (h_idle | ~4'(5'h1E << k)) == XGC_ALL) begin
        dt_hit = 1'b1;
        dt_k   = 2'(k);
      end
    end
  end

  always_comb begin
    d_w     = '{{1'b1, XG_ERR}, {1'b1, XG_ERR}, {1'b1, XG_ERR}, {1'b1, XG_ERR}}; // RQ21
    dec_d   = DEC_ERR;
    xyz_d   = xyz_q;
    seqok_d = seqok_q;
    if (&h_de && dec_q != DEC_IDLE) begin
      d_w   = '{to_xg(hold_q[0]), to_xg(hold_q[1]), to_xg(hold_q[2]), to_xg(hold_q[3])}; // RQ18
      dec_d = DEC_DATA;
    end else if (hold_q[0][9:8] == 2'b10 && &h_de[3:1] && dec_q == DEC_IDLE) begin
      d_w   = '{{1'b1, XG_SOP}, to_xg(hold_q[1]), to_xg(hold_q[2]), to_xg(hold_q[3])}; // RQ18
      dec_d = DEC_DATA;
    end else if (&h_idle && dec_q != DEC_DATA) begin
      d_w   = '{4{{1'b1, XG_IDLE}}}; // RQ19
      dec_d = DEC_IDLE;
    end else if (dt_hit && dec_q == DEC_DATA) begin
      for (int i = 0; i < 4; i++) begin
        d_w[i] = (2'(i) < dt_k) ? to_xg(hold_q[i]) : {1'b1, XG_IDLE};
      end
      d_w[dt_k] = {1'b1, XG_TERM}; // RQ19
      dec_d     = DEC_IDLE;
    end else if (&h_lpi || h_idle == 4'h3 && h_lpi == 4'hC) begin
      d_w   = '{4{{1'b1, XG_LPI}}}; // RQ20
      dec_d = DEC_IDLE;
    end else if (h_lpi == 4'h3 && h_idle == 4'hC) begin
      d_w   = '{4{{1'b1, XG_IDLE}}}; // RQ20
      dec_d = DEC_IDLE;
    end else if (first_half) begin
      d_w   = '{4{{1'b1, XG_IDLE}}};
      dec_d = DEC_IDLE;
      if (next_half_present) begin
        dec_d   = DEC_SEQ; // RQ21
        xyz_d   = xyz;
        seqok_d = pat_ok;
        if (pat_ok) begin
          d_w = '{{1'b1, XG_SEQ}, {1'b0, xyz[7:0]}, {1'b0, xyz[15:8]}, {1'b0, xyz[23:16]}}; // RQ22
        end
      end
    end else if (h_shape && !hold_q[3][7] && dec_q == DEC_SEQ) begin
      d_w   = '{4{{1'b1, XG_IDLE}}};
      dec_d = DEC_IDLE; // RQ21
      if (seqok_q) begin
        d_w = '{{1'b1, XG_SEQ}, {1'b0, xyz_q[7:0]}, {1'b0, xyz_q[15:8]}, {1'b0, xyz_q[23:16]}};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_q         <= '{SYM_IDLE, SYM_IDLE, SYM_IDLE, SYM_IDLE};
      hold_v_q       <= 1'b0;
      dec_q          <= DEC_IDLE;
      xyz_q          <= '0;
      seqok_q        <= 1'b0;
      rxd            <= {4{XG_IDLE}};
      rxc            <= XGC_ALL;
      rx_word_strobe <= 1'b0;
    end else begin
      rx_word_strobe <= dec_go;
      if (grp_emit) begin
        hold_q   <= grp_out;
        hold_v_q <= 1'b1;
      end
      if (dec_go) begin
        dec_q   <= dec_d;
        xyz_q   <= xyz_d;
        seqok_q <= seqok_d;
        rxd     <= {d_w[3][7:0], d_w[2][7:0], d_w[1][7:0], d_w[0][7:0]};
        rxc     <= {d_w[3][8], d_w[2][8], d_w[1][8], d_w[0][8]};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_seq_first;
    enc_push && is_seqw && enc_q == ENC_IDLE;
  endsequence
  sequence s_seq_second;
    enc_push && is_seqw && enc_q == ENC_SEQ;
  endsequence

  property p_dic_bound;
    dic_q <= DIC_MAX;
  endproperty
  a_dic_bound: assert property (p_dic_bound) else $error("deficit out of range"); // RQ16
  property p_dic_step;
    !(mis0 || mis02) |=> $stable(dic_q);
  endproperty
  a_dic_step: assert property (p_dic_step) else $error("deficit moved without edit"); // RQ15
  property p_dat_idx0;
    prev_q[9:8] == 2'b00 && cur[9] |=> slot_q == 2'h1;
  endproperty
  a_dat_idx0: assert property (p_dat_idx0) else $error("data after idle off index 0"); // RQ12
  property p_lpi_idx;
    !need0 && need02 |=> slot_q[0];
  endproperty
  a_lpi_idx: assert property (p_lpi_idx) else $error("LPI transition on odd index"); // RQ13
  property p_set_idx;
    set_start |=> slot_q == 2'h1;
  endproperty
  a_set_idx: assert property (p_set_idx) else $error("set start off index 0"); // RQ14
  property p_enc_idle;
    enc_push && &ln_idle |=> enc_q == ENC_IDLE;
  endproperty
  a_enc_idle: assert property (p_enc_idle) else $error("idle word left wrong state"); // RQ1
  property p_seq_hold;
    s_seq_first |=> enc_q == ENC_SEQ && s23_q == $past(seq_w[31:16]);
  endproperty
  a_seq_hold: assert property (p_seq_hold) else $error("sequence half not kept"); // RQ24
  property p_seq_pair;
    s_seq_first ##1 s_seq_second |=> enc_q == ENC_IDLE;
  endproperty
  a_seq_pair: assert property (p_seq_pair) else $error("sequence pair not closed"); // RQ4
  property p_seq_mark;
    s_seq_first |-> !seq_w[7] && seq_w[15] && !seq_w[31]
                    && seq_w[6] == (seq_w[2] ? seq_w[5] : seq_w[7]);
  endproperty
  a_seq_mark: assert property (p_seq_mark) else $error("packed byte marks wrong"); // RQ8
  property p_ser_last;
    ser_end |=> tx_sym_q == $past(word_q[3*SYM_W +: SYM_W]) ##1 tx_sym_q == word_q[9:0];
  endproperty
  a_ser_last: assert property (p_ser_last) else $error("serializer order wrong"); // RQ9
  property p_dec_lpi;
    dec_go && &h_lpi |=> dec_q == DEC_IDLE && rxc == XGC_ALL && rxd == {4{XG_LPI}};
  endproperty
  a_dec_lpi: assert property (p_dec_lpi) else $error("LPI group decoded wrong"); // RQ20
endmodule

// *** symbol_map_pkg.sv ***
// Purpose: Shared constants and types for the lane/symbol mapper
// Assumes: Symbol layout {valid, error, data[7:0]}
// Notes:   XGMII lane n is txd/rxd[8n+7:8n] with control bit n
package symbol_map_pkg;
  localparam int SYM_W      = 10;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 4 * SYM_W;
  localparam logic [1:0] DIC_MAX   = 2'h3;
  localparam logic [1:0] DIC_RESET = 2'h0;
  localparam logic [1:0] SLOT_RST  = 2'h0;
  localparam logic [7:0] XG_IDLE  = 8'h07;
  localparam logic [7:0] XG_LPI   = 8'h06;
  localparam logic [7:0] XG_SOP   = 8'hFB;
  localparam logic [7:0] XG_TERM  = 8'hFD;
  localparam logic [7:0] XG_ERR   = 8'hFE;
  localparam logic [7:0] XG_SEQ   = 8'h9C;
  localparam logic [7:0] XG_SIG   = 8'h5C;
  localparam logic [7:0] PREAMBLE = 8'h55;
  localparam logic [9:0] SYM_IDLE = 10'h000;
  localparam logic [9:0] SYM_LPI  = 10'h101;
  localparam logic [9:0] SYM_CE   = 10'h10F;
  localparam logic [9:0] SYM_SEQ  = 10'h19C;
  localparam logic [9:0] SYM_ERR  = 10'h300;
  localparam logic [3:0] XGC_ALL  = 4'hF;
  localparam logic [3:0] SEQ_PAT  = 4'h6;
  typedef logic [9:0] sym_t;
  typedef enum logic [2:0] {
    ENC_IDLE = 3'b001,
    ENC_DATA = 3'b010,
    ENC_SEQ  = 3'b100
  } enc_state_t;
  typedef enum logic [3:0] {
    DEC_IDLE = 4'b0001,
    DEC_DATA = 4'b0010,
    DEC_SEQ  = 4'b0100,
    DEC_ERR  = 4'b1000
  } dec_state_t;
endpackage

// *** tb_quad_lane_byte_symbol_mapper.sv ***
// Purpose: Self-checking bench for the lane/symbol mapper
// Assumes: Symbol inputs driven by the bench, XGMII words by the source
// Notes:   All-idle groups and words are skipped on both sides, since
//          FIFO gaps and alignment shifts add them at unknown places
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_quad_lane_byte_symbol_mapper
  import symbol_map_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tx_even = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] txd, rxd;
  logic [3:0]  txc, rxc;
  logic        tx_word_valid, tx_word_ready, tx_symbol_valid, tx_symbol_error;
  logic [7:0]  tx_symbol_data;
  logic        rx_symbol_valid = 1'b0;
  logic        rx_symbol_error = 1'b0;
  logic [7:0]  rx_symbol_data = 8'h00;
  logic        rx_word_strobe;
  int          fail_count = 0;
  int          n_tests = 0;
  int          pos = 0;
  bit          locked = 1'b0;
  bit          saw_full = 1'b0;
  logic [1:0]  enc_st = 2'h0;
  logic [15:0] enc_hold;
  logic [39:0] grp, exp_g;
  logic [39:0] tx_exp[$];
  logic [35:0] rx_exp[$], rx_got[$];
  sym_t        rx_q[$];
  int          corner[$] = {1, 5, 5, 5, 0, 5, 1, 7, 7, 4, 14, 24, 34, 3, 6, 8, 2, 5, 1, 5, 5};

  quad_lane_byte_symbol_mapper dut (
    .clk(clk), .rst_n(rst_n), .txd(txd), .txc(txc), .tx_word_valid(tx_word_valid),
    .tx_word_ready(tx_word_ready), .tx_even(tx_even), .tx_symbol_valid(tx_symbol_valid),
    .tx_symbol_error(tx_symbol_error), .tx_symbol_data(tx_symbol_data),
    .rx_symbol_valid(rx_symbol_valid), .rx_symbol_error(rx_symbol_error),
    .rx_symbol_data(rx_symbol_data), .rxd(rxd), .rxc(rxc), .rx_word_strobe(rx_word_strobe)
  );
  xgmii_word_source src (
    .clk(clk), .slow(slow), .txd(txd), .txc(txc), .tx_word_valid(tx_word_valid),
    .tx_word_ready(tx_word_ready)
  );

  always #5 clk = ~clk;

  function automatic logic [31:0] pack(input logic [7:0] x, y, z, input bit sig);
    logic [7:0] s[4];
    s[0] = {2'b00, x[5:0]};
    s[1] = {2'b10, y[3:0], x[7:6]};
    s[2] = {!sig, 1'b0, z[1:0], y[7:4]};
    s[3] = {2'b00, z[7:2]};
    for (int i = 0; i < 4; i++) s[i][6] = s[i][2] ? s[i][5] : s[i][7];
    return {s[3], s[2], s[1], s[0]};
  endfunction

  function automatic int kind(input logic [7:0] b, input logic c);
    if (!c) return 0;
    case (b)
      XG_ERR:  return 1;
      XG_IDLE: return 2;
      XG_LPI:  return 3;
      XG_SOP:  return 4;
      XG_TERM: return 5;
      XG_SEQ:  return 6;
      XG_SIG:  return 7;
      default: return 8;
    endcase
  endfunction

  // Encoder model; kinds: 0 data, 1 error, 2 idle, 3 LPI, 5 terminate
  function automatic logic [39:0] enc(input logic [35:0] w);
    int          k[4];
    sym_t        s[4];
    int          t, ni, nl;
    bit          de, ok;
    logic [31:0] p;
    de = 1;
    ok = 1;
    t = 4;
    ni = 0;
    nl = 0;
    for (int i = 0; i < 4; i++) begin
      k[i] = kind(w[8*i+:8], w[32+i]);
      s[i] = k[i] == 0 ? {2'b10, w[8*i+:8]} : (k[i] == 1 ? {2'b11, XG_ERR} : SYM_IDLE);
      de &= k[i] < 2;
      ni += k[i] == 2;
      nl += k[i] == 3;
    end
    for (int i = 3; i >= 0; i--) if (k[i] == 5) t = i;
    for (int i = 0; i < 4; i++) ok &= i < t ? k[i] < 2 : (i > t ? k[i] == 2 : 1'b1);
    if (de || nl == 4) begin
      if (nl == 4) s = '{default: SYM_LPI};
      enc_st = 2'h1;
    end else if (ni == 4) begin
      enc_st = 2'h0;
    end else if (k[0] == 4 && k[1] < 2 && k[2] < 2 && k[3] < 2) begin
      s[0] = {2'b10, PREAMBLE};
      enc_st = 2'h1;
    end else if (t < 4 && ok) begin
      enc_st = t == 0 ? 2'h0 : 2'h1;
    end else if ((k[0] == 6 || k[0] == 7) && k[1] + k[2] + k[3] == 0) begin
      p = pack(w[15:8], w[23:16], w[31:24], k[0] == 7);
      case (enc_st)
        2'h0: begin
          s = '{SYM_SEQ, {2'b10, p[7:0]}, SYM_SEQ, {2'b10, p[15:8]}};
          enc_hold = p[31:16];
          enc_st = 2'h2;
        end
        2'h2: begin
          s = '{SYM_SEQ, {2'b10, enc_hold[7:0]}, SYM_SEQ, {2'b10, enc_hold[15:8]}};
          enc_st = 2'h0;
        end
        default: begin
          s = '{default: SYM_IDLE};
          enc_st = 2'h0;
        end
      endcase
    end else begin
      s = '{default: SYM_ERR};
      enc_st = 2'h1;
    end
    return {s[3], s[2], s[1], s[0]};
  endfunction

  function automatic bit idle4(input logic [39:0] g);
    return ~|{g[39:38], g[29:28], g[19:18], g[9:8]};
  endfunction

  // Word kinds: 1 idle, 2 LPI, 3 start, 4 terminate, 5 seq, 6 error, 7 signal, 8 bad
  function automatic logic [35:0] gen(input int t, input int l);
    logic [31:0] d;
    d = $urandom;
    case (t)
      1: return {4'hF, {4{XG_IDLE}}};
      2: return {4'hF, {4{XG_LPI}}};
      3: return {4'h1, d[31:8], XG_SOP};
      4: begin
        for (int i = 0; i < 4; i++) if (i > l) d[8*i+:8] = XG_IDLE;
        d[8*l+:8] = XG_TERM;
        return {4'hF << l, d};
      end
      5: return {4'h1, d[31:8], XG_SEQ};
      6: return {4'h4, d[31:24], XG_ERR, d[15:0]};
      7: return {4'h1, d[31:8], XG_SIG};
      8: return {4'h1, d[31:8], XG_IDLE};
      default: return {4'h0, d};
    endcase
  endfunction

  task automatic send(input logic [35:0] w);
    logic [39:0] e;
    e = enc(w);
    if (!idle4(e)) tx_exp.push_back(e);
    src.push(w);
  endtask

  task automatic rx_set(input logic [31:0] p, input int n);
    for (int i = 0; i < n; i++) begin
      rx_q.push_back(SYM_SEQ);
      rx_q.push_back({2'b10, p[8*i+:8]});
    end
    repeat (12) rx_q.push_back({2'b00, 8'($urandom)});
  endtask

  task automatic rx_build();
    logic [7:0]  d[7];
    logic [23:0] x;
    foreach (d[i]) d[i] = $urandom;
    d[0] = PREAMBLE;
    x = $urandom;
    repeat (12) rx_q.push_back({2'b00, 8'($urandom)});
    foreach (d[i]) rx_q.push_back({2'b10, d[i]});
    rx_q.push_back(SYM_CE);
    rx_exp.push_back({4'h1, d[3], d[2], d[1], XG_SOP});
    rx_exp.push_back({4'h8, XG_TERM, d[6], d[5], d[4]});
    repeat (12) rx_q.push_back({2'b00, 8'($urandom)});
    for (int i = 0; i < 5; i++) rx_q.push_back(i == 2 ? SYM_ERR : {2'b10, d[i]});
    rx_exp.push_back({4'h5, d[3], XG_ERR, d[1], XG_SOP});
    rx_exp.push_back({4'hE, XG_IDLE, XG_IDLE, XG_TERM, d[4]});
    repeat (12) rx_q.push_back({2'b00, 8'($urandom)});
    repeat (8) rx_q.push_back(SYM_LPI);
    repeat (2) rx_exp.push_back({4'hF, {4{XG_LPI}}});
    rx_set(32'h0000_0000, 0);
    rx_set(pack(x[7:0], x[15:8], x[23:16], 1'b0), 4);
    repeat (2) rx_exp.push_back({4'h1, x, XG_SEQ});
    rx_set(pack(x[7:0], x[15:8], x[23:16], 1'b0), 2);
    rx_set(pack(x[7:0], x[15:8], x[23:16], 1'b1), 4);
  endtask

  task automatic test_done();
    $display("compares=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    tx_even <= ~tx_even;
    if (rx_q.size() > 0) begin
      {rx_symbol_valid, rx_symbol_error, rx_symbol_data} <= rx_q.pop_front();
    end else begin
      {rx_symbol_valid, rx_symbol_error, rx_symbol_data} <= {2'b00, 8'($urandom)};
    end
  end

  always @(posedge clk) begin
    if (rst_n) begin
      if (tx_word_valid && !tx_word_ready) begin
        saw_full = 1'b1;
        slow <= 1'b1;
      end
      if (rx_word_strobe === 1'b1 && {rxc, rxd} !== {4'hF, {4{XG_IDLE}}}) begin
        rx_got.push_back({rxc, rxd});
      end
      if (tx_symbol_valid | tx_symbol_error) locked = 1'b1;
      if (locked) begin
        `CHK(tx_even, pos[0] == 1'b0)
        grp[10*pos+:10] = {tx_symbol_valid, tx_symbol_error, tx_symbol_data};
        pos = (pos + 1) % 4;
        if (pos == 0 && !idle4(grp)) begin
          exp_g = tx_exp.size() > 0 ? tx_exp.pop_front() : 'x;
          `CHK(grp, exp_g)
        end
      end
    end
  end

  initial begin
    logic [35:0] r;
    int          k;
    void'($urandom(45467));
    rx_build();
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK({rxc, rxd, rx_word_strobe}, {4'hF, {4{XG_IDLE}}, 1'b0})
    `CHK({tx_symbol_valid, tx_symbol_error, tx_symbol_data}, SYM_IDLE)
    rst_n = 1'b1;
    $display("reset test done");
    foreach (corner[i]) send(gen(corner[i] % 10, corner[i] / 10));
    repeat (40) send(gen($urandom % 9, $urandom % 4));
    k = 0;
    while ((tx_exp.size() > 0 || rx_q.size() > 0) && k < 5000) begin
      @(posedge clk);
      k++;
    end
    repeat (40) @(posedge clk);
    if (k == 5000) fail_count++;
    `CHK(saw_full, 1'b1)
    $display("tx test done");
    `CHK(rx_got.size(), rx_exp.size())
    foreach (rx_exp[i]) begin
      r = i < rx_got.size() ? rx_got[i] : 'x;
      `CHK(r, rx_exp[i])
    end
    $display("rx test done");
    test_done();
  end
endmodule

// *** xgmii_word_source.sv ***
// Purpose: XGMII word source standing in for the reconciliation side
// Assumes: Words are queued by the bench through push
// Notes:   Holds each word until taken; slow adds random gaps
`timescale 1ns/1ps
module xgmii_word_source (
  input  wire logic   clk,
  input  wire logic   slow,
  output logic [31:0] txd,
  output logic [3:0]  txc,
  output logic        tx_word_valid,
  input  wire logic   tx_word_ready
);
  logic [35:0] q[$];
  bit          took = 1'b0;
  bit          go;
  initial begin
    txd = 32'h0000_0000;
    txc = 4'h0;
    tx_word_valid = 1'b0;
  end
  function automatic void push(input logic [35:0] w);
    q.push_back(w);
  endfunction
  always @(posedge clk) begin
    took = tx_word_valid && tx_word_ready;
  end
  // Offered word stays put until an edge sees ready
  always @(negedge clk) begin
    if (took) begin
      void'(q.pop_front());
    end
    go = q.size() > 0 && ((tx_word_valid && !took) || !slow || $urandom_range(2) == 0);
    // Idle bus shows the inverse of its last value, so the stale word returns every second idle cycle
    {txc, txd} = go ? q[0] : ~{txc, txd};
    tx_word_valid = go;
  end
endmodule
